// *** logic/io_config_and_dac_write_ctrl.sv ***
/*
 * Control registers, pin function resolution and DAC input/active registers of an
 * eight-channel configurable analog/digital I/O device, written over the two-wire bus.
 * Assumes the ADC sequencer reports conversions on the same clock and that analog and pad
 * cells act on the per-pin enables driven here.
 */
// Function
// R01: Host writes zeros to unused general control bits 15..10 and 3..0.
// R02: Precharge set powers the enabled ADC buffer only during conversions.
// R03: ADC buffer stays disabled while enable bit is zero, its reset value.
// R04: Lock bit set discards writes to pin configuration registers.
// R05: Broadcast bit makes DAC writes load every DAC-configured pin.
// R06: ADC range bit selects one or two reference spans.
// R07: DAC range bit selects one or two reference spans.
// R08: Pointer upper nibble zero selects control register by low nibble.
// R09: After reset every pin is pulled down with no function.
// R10: Data bit n of a pin map register assigns that function to pin n.
// R11: Pin set in several function maps takes the latest written function.
// R12: DAC and ADC may share a pin; DAC drives, ADC samples.
// R13: Pin set as input and output acts as output; input reads pad.
// R14: Host reconfigures only when idle and unlocked.
// R15: Output pins choose push-pull or open-drain; pins may be three-stated.
// R16: DAC write pointer stores two data bytes into selected DAC input register.
// R17: Input-to-active DAC transfer obeys the load-mode setting.
// R18: Low nibble codes 4,5,6,8,10,12,13 select the pin maps.
// R19: Load mode 00 direct, 01 hold, 10 load all then 01, 11 reserved.
// R20: Locked configuration writes are acknowledged but do not update.
`timescale 1ns/1ps
`include "io_cfg.svh"

module io_config_and_dac_write_ctrl #(
	parameter int PINS = 8,
	parameter int DAC_BITS = 12,
	parameter logic [6:0] SLAVE_ADDR = 7'h10
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic conversion_active,
	input wire logic [PINS-1:0] io_pin_n_in,
	output logic [PINS-1:0] io_pin_n_out,
	output logic [PINS-1:0] io_pin_n_oe,
	output logic [PINS-1:0] pulldown_en,
	output logic [PINS-1:0] dac_drive_en,
	output logic [PINS-1:0] adc_sample_en,
	output logic [PINS-1:0] gpio_in_state,
	output logic [PINS-1:0][DAC_BITS-1:0] dac_active,
	output logic adc_buf_power,
	output logic adc_range_2x,
	output logic dac_range_2x
);
	logic frame_start;
	logic byte_valid;
	logic [7:0] byte_data;
	io_pkg::byte_phase_e phase;
	logic [7:0] pointer;
	logic [7:0] msb;
	logic write_done;
	logic [`GPC_HI:`GPC_LO] gen_ctrl;
	logic [PINS-1:0] adc_map;
	logic [PINS-1:0] dac_map;
	logic [PINS-1:0] pulldown_map;
	logic [PINS-1:0] gpo_map;
	logic [PINS-1:0] gpi_map;
	logic [PINS-1:0] gpo_data;
	logic [PINS-1:0] open_drain_map;
	logic [PINS-1:0] tristate_map;
	logic [1:0] load_mode;
	logic [PINS-1:0][DAC_BITS-1:0] dac_input;
	logic [PINS-1:0] pad_sync1;
	logic [PINS-1:0] pad_sync2;
	logic ctrl_write;
	logic dac_write;
	logic map_write;
	logic [3:0] reg_sel;
	logic [PINS-1:0] wdata;
	logic [DAC_BITS-1:0] dac_wdata;
	logic [PINS-1:0] dac_targets;

	i2c_byte_rx #(
		.SLAVE_ADDR(SLAVE_ADDR)
	) u_rx (
		.clk(clk),
		.nrst(nrst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.frame_start(frame_start),
		.byte_valid(byte_valid),
		.byte_data(byte_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Frame assembly: pointer, then MSB, then LSB; the LSB commits the write.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= io_pkg::PH_POINTER;
			pointer <= 8'h00;
			msb <= 8'h00;
		end else if (frame_start) begin
			phase <= io_pkg::PH_POINTER;
		end else if (byte_valid) begin
			unique case (phase)
				io_pkg::PH_POINTER: begin
					pointer <= byte_data;
					phase <= io_pkg::PH_MSB;
				end
				io_pkg::PH_MSB: begin
					msb <= byte_data;
					phase <= io_pkg::PH_LSB;
				end
				io_pkg::PH_LSB: begin
					phase <= io_pkg::PH_POINTER;
				end
			endcase
		end
	end

	assign write_done = byte_valid && !frame_start && phase == io_pkg::PH_LSB;
	assign reg_sel = pointer[3:0];
	assign ctrl_write = write_done && pointer[7:4] == `PTR_MODE_CTRL; // [R08]
	assign dac_write = write_done && pointer[7:4] == `PTR_MODE_DAC; // [R16]
	assign wdata = byte_data[PINS-1:0]; // [R10]
	assign dac_wdata = {msb[3:0], byte_data};
	// Pin map selects; a set lock swallows the whole write. [R18] [R04] [R20]
	assign map_write = ctrl_write && !gen_ctrl[`GPC_LOCK] &&
		(reg_sel == `REG_ADC_MAP || reg_sel == `REG_DAC_MAP ||
		reg_sel == `REG_PULLDOWN_MAP || reg_sel == `REG_GPO_MAP ||
		reg_sel == `REG_GPI_MAP || reg_sel == `REG_OPEN_DRAIN ||
		reg_sel == `REG_TRISTATE);

	////////////////////////////////////////////////////////////////////////////////
	// General-purpose control. Only bits 9..4 are stored, so host padding never matters.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gen_ctrl <= `RST_GEN_CTRL;
		end else if (ctrl_write && reg_sel == `REG_GEN_CTRL) begin
			gen_ctrl <= {msb[`GPC_PRECHARGE-8], msb[`GPC_BUF_EN-8], byte_data[7:4]};
		end
	end

	assign adc_buf_power = gen_ctrl[`GPC_BUF_EN] && // [R03]
		(!gen_ctrl[`GPC_PRECHARGE] || conversion_active); // [R02]
	assign adc_range_2x = gen_ctrl[`GPC_ADC_RANGE]; // [R06]
	assign dac_range_2x = gen_ctrl[`GPC_DAC_RANGE]; // [R07]

	////////////////////////////////////////////////////////////////////////////////
	// Pin maps. A write claims its set pins and strips them from every map that cannot
	// coexist, so the latest writer owns the pin. ADC/DAC and input/output may share.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adc_map <= `RST_MAP;
			dac_map <= `RST_MAP;
			pulldown_map <= `RST_PULLDOWN; // [R09]
			gpo_map <= `RST_MAP;
			gpi_map <= `RST_MAP;
			open_drain_map <= `RST_MAP;
			tristate_map <= `RST_MAP;
		end else if (map_write) begin
			unique case (reg_sel)
				`REG_ADC_MAP: begin
					adc_map <= wdata;
					pulldown_map <= pulldown_map & ~wdata; // [R11]
					gpo_map <= gpo_map & ~wdata;
					gpi_map <= gpi_map & ~wdata;
					tristate_map <= tristate_map & ~wdata;
				end
				`REG_DAC_MAP: begin
					dac_map <= wdata; // [R12]
					pulldown_map <= pulldown_map & ~wdata; // [R11]
					gpo_map <= gpo_map & ~wdata;
					gpi_map <= gpi_map & ~wdata;
					tristate_map <= tristate_map & ~wdata;
				end
				`REG_GPO_MAP, `REG_GPI_MAP: begin
					if (reg_sel == `REG_GPO_MAP) begin
						gpo_map <= wdata; // [R13]
					end else begin
						gpi_map <= wdata;
					end
					adc_map <= adc_map & ~wdata; // [R11]
					dac_map <= dac_map & ~wdata;
					pulldown_map <= pulldown_map & ~wdata;
					tristate_map <= tristate_map & ~wdata;
				end
				`REG_PULLDOWN_MAP, `REG_TRISTATE: begin
					if (reg_sel == `REG_PULLDOWN_MAP) begin
						pulldown_map <= wdata;
						tristate_map <= tristate_map & ~wdata;
					end else begin
						tristate_map <= wdata; // [R15]
						pulldown_map <= pulldown_map & ~wdata;
					end
					adc_map <= adc_map & ~wdata; // [R11]
					dac_map <= dac_map & ~wdata;
					gpo_map <= gpo_map & ~wdata;
					gpi_map <= gpi_map & ~wdata;
				end
				`REG_OPEN_DRAIN: begin
					open_drain_map <= wdata; // [R15]
				end
				default: begin
				end
			endcase
		end
	end

	// Output data is not a configuration register, so the lock leaves it writable.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gpo_data <= `RST_MAP;
		end else if (ctrl_write && reg_sel == `REG_GPO_DATA) begin
			gpo_data <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pads. Open drain only ever pulls low; an output pin that is also an input reads its
	// own pad level back through the synchroniser.
	assign io_pin_n_out = gpo_data & ~open_drain_map;
	assign io_pin_n_oe = gpo_map & ~tristate_map & (~open_drain_map | ~gpo_data); // [R15] [R13]
	assign pulldown_en = pulldown_map; // [R09]
	assign dac_drive_en = dac_map; // [R12]
	assign adc_sample_en = adc_map; // [R12]

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pad_sync1 <= `RST_MAP;
			pad_sync2 <= `RST_MAP;
			gpio_in_state <= `RST_MAP;
		end else begin
			pad_sync1 <= io_pin_n_in;
			pad_sync2 <= pad_sync1;
			gpio_in_state <= pad_sync2 & gpi_map; // [R13]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DAC input and active registers under the load mode.
	assign dac_targets = gen_ctrl[`GPC_BROADCAST] ? dac_map : // [R05]
		PINS'(1) << pointer[2:0]; // [R16]

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			load_mode <= `RST_LOAD_MODE;
		end else if (ctrl_write && reg_sel == `REG_LOAD_MODE) begin
			load_mode <= byte_data[1:0];
		end else if (load_mode == `LOAD_ALL) begin
			load_mode <= `LOAD_HOLD; // [R19]
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dac_input <= '0;
			dac_active <= '0;
		end else begin
			for (int i = 0; i < PINS; i++) begin
				if (dac_write && dac_targets[i]) begin
					dac_input[i] <= dac_wdata; // [R16]
					if (load_mode == `LOAD_DIRECT) begin
						dac_active[i] <= dac_wdata; // [R17] [R19]
					end
				end else if (load_mode == `LOAD_ALL) begin
					dac_active[i] <= dac_input[i]; // [R19]
				end
			end
		end
	end
endmodule : io_config_and_dac_write_ctrl

// *** logic/io_cfg.svh ***
/*
 * Offsets, field positions, reset values and codes of the configurable I/O control logic.
 * Assumes it is included by bare name from the design modules.
 */
`ifndef IO_CFG_SVH
`define IO_CFG_SVH

// Pointer byte mode nibbles.
`define PTR_MODE_CTRL 4'h0
`define PTR_MODE_DAC 4'h1

// Control register selects (pointer low nibble).
`define REG_GEN_CTRL 4'h3
`define REG_ADC_MAP 4'h4
`define REG_DAC_MAP 4'h5
`define REG_PULLDOWN_MAP 4'h6
`define REG_LOAD_MODE 4'h7
`define REG_GPO_MAP 4'h8
`define REG_GPO_DATA 4'h9
`define REG_GPI_MAP 4'hA
`define REG_OPEN_DRAIN 4'hC
`define REG_TRISTATE 4'hD

// General-purpose control field positions.
`define GPC_PRECHARGE 9
`define GPC_BUF_EN 8
`define GPC_LOCK 7
`define GPC_BROADCAST 6
`define GPC_ADC_RANGE 5
`define GPC_DAC_RANGE 4
`define GPC_LO 4
`define GPC_HI 9

// Reset values.
`define RST_GEN_CTRL 6'h00
`define RST_MAP 8'h00
`define RST_PULLDOWN 8'hFF
`define RST_LOAD_MODE 2'h0

// Load-mode codes.
`define LOAD_DIRECT 2'h0
`define LOAD_HOLD 2'h1
`define LOAD_ALL 2'h2

`endif

// *** logic/io_pkg.sv ***
/*
 * Types shared by the configurable I/O control logic.
 * Assumes io_cfg.svh sits beside it.
 */
package io_pkg;
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_SHIFT,
		RX_ACK
	} rx_state_e;

	typedef enum logic [1:0] {
		PH_POINTER,
		PH_MSB,
		PH_LSB
	} byte_phase_e;
endpackage : io_pkg

// *** logic/i2c_byte_rx.sv ***
/*
 * Two-wire serial write receiver: start/stop detection, address match, byte shift and
 * acknowledge. Assumes clk oversamples SCL by a wide margin; SDA is open drain.
 */
`timescale 1ns/1ps
`include "io_cfg.svh"

module i2c_byte_rx #(
	parameter logic [6:0] SLAVE_ADDR = 7'h10
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic frame_start,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	io_pkg::rx_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic is_addr;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection on the second stage only.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] && !scl_q;
	assign scl_fall = !scl_sync[1] && scl_q;
	assign start_cond = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
	assign stop_cond = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Byte engine. Every byte of a selected write is acknowledged, locked or not. [R20]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= io_pkg::RX_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			is_addr <= 1'b0;
			sda_oe <= 1'b0;
			frame_start <= 1'b0;
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
		end else begin
			frame_start <= 1'b0;
			byte_valid <= 1'b0;
			if (start_cond) begin
				state <= io_pkg::RX_SHIFT;
				bit_cnt <= 4'h0;
				is_addr <= 1'b1;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state <= io_pkg::RX_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (state)
					io_pkg::RX_IDLE: begin
					end
					io_pkg::RX_SHIFT: begin
						if (scl_rise && bit_cnt != 4'h8) begin
							shift <= {shift[6:0], sda_sync[1]};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							if (is_addr) begin
								// Reads are not served here, so a read address is not taken.
								if (shift[7:1] == SLAVE_ADDR && !shift[0]) begin
									state <= io_pkg::RX_ACK;
									sda_oe <= 1'b1;
									frame_start <= 1'b1;
								end else begin
									state <= io_pkg::RX_IDLE;
								end
							end else begin
								state <= io_pkg::RX_ACK;
								sda_oe <= 1'b1;
								byte_valid <= 1'b1;
								byte_data <= shift;
							end
						end
					end
					io_pkg::RX_ACK: begin
						if (scl_fall) begin
							state <= io_pkg::RX_SHIFT;
							sda_oe <= 1'b0;
							bit_cnt <= 4'h0;
							is_addr <= 1'b0;
						end
					end
				endcase
			end
		end
	end
endmodule : i2c_byte_rx

// *** verification/io_ctrl_properties.sv ***
/*
 * Port-level checks of the I/O control block, bound into its top module.
 * Assumes one clock and that conversion_active only toggles while the bus is quiet.
 */
`timescale 1ns/1ps
module io_ctrl_properties #(
	parameter int PINS = 8,
	parameter int DAC_BITS = 12
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic conversion_active,
	input wire logic [PINS-1:0] io_pin_n_in,
	input wire logic [PINS-1:0] io_pin_n_oe,
	input wire logic [PINS-1:0] pulldown_en,
	input wire logic [PINS-1:0] dac_drive_en,
	input wire logic [PINS-1:0] adc_sample_en,
	input wire logic [PINS-1:0] gpio_in_state,
	input wire logic [PINS-1:0][DAC_BITS-1:0] dac_active,
	input wire logic adc_buf_power,
	input wire logic adc_range_2x,
	input wire logic dac_range_2x
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_reset_pins: assert property ($rose(nrst) |-> pulldown_en == '1
		&& (dac_drive_en | adc_sample_en | io_pin_n_oe) == '0) else $error("pins not reset");
	chk_reset_analog: assert property ($rose(nrst) |-> !adc_buf_power
		&& !adc_range_2x && !dac_range_2x) else $error("analog controls not reset");
	chk_buf_stays_on: assert property ($rose(conversion_active) && $past(adc_buf_power)
		&& !sda_oe |-> adc_buf_power) else $error("buffer lost power");
	chk_buf_stays_off: assert property ($fell(conversion_active) && !$past(adc_buf_power)
		&& !sda_oe |-> !adc_buf_power) else $error("disabled buffer powered");
	// The pad path is three flops deep, so four quiet cycles leave no stale ones.
	chk_gpi_follows: assert property ($stable(io_pin_n_in) [*4]
		|-> (gpio_in_state & ~io_pin_n_in) == '0) else $error("input state not from pad");
	chk_dac_no_pad: assert property ((dac_drive_en & io_pin_n_oe) == '0)
		else $error("dac pin driven digitally");
	chk_pulldown_alone: assert property ((pulldown_en
		& (dac_drive_en | adc_sample_en | io_pin_n_oe)) == '0) else $error("pull-down shared");
	chk_ack_low: assert property (sda_oe |-> !sda_out) else $error("ack not low");
	// Both bus clock halves last at least four clocks, so an acknowledge never stands shorter.
	chk_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*4])
		else $error("ack too short");
	chk_dac_quiet: assert property (!$stable(dac_active)
		|-> sda_oe || $past(sda_oe) || $past(sda_oe, 2)) else $error("dac moved off the bus");
	chk_maps_quiet: assert property (!$stable({pulldown_en, dac_drive_en, adc_sample_en,
		adc_range_2x, dac_range_2x}) |-> sda_oe || $past(sda_oe)) else $error("map moved");
	cover property (adc_buf_power && !conversion_active);
	cover property ((dac_drive_en & adc_sample_en) != '0);
	cover property (gpio_in_state != '0);
	cover property ($changed(dac_active));
endmodule : io_ctrl_properties

bind io_config_and_dac_write_ctrl io_ctrl_properties #(.PINS(PINS), .DAC_BITS(DAC_BITS))
	u_io_ctrl_properties (.clk, .nrst, .sda_out, .sda_oe, .conversion_active, .io_pin_n_in,
	.io_pin_n_oe, .pulldown_en, .dac_drive_en, .adc_sample_en, .gpio_in_state, .dac_active,
	.adc_buf_power, .adc_range_2x, .dac_range_2x);

// *** verification/i2c_host_model.sv ***
/*
 * Two-wire bus host that writes address, pointer, MSB and LSB frames.
 * Assumes a pulled-up SDA resolved outside; SCL halves are five clocks long.
 */
`timescale 1ns/1ps
module i2c_host_model (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	int nacks = 0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic send_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			scl <= 1'b0;
			tick(2);
			// The ninth slot releases SDA so the device can answer.
			sda_low <= (i == 0) ? 1'b0 : ~b[i-1];
			tick(3);
			scl <= 1'b1;
			tick(3);
			if (i == 0 && sda_line !== 1'b0) nacks++;
			tick(2);
		end
	endtask : send_byte
	task automatic write_frame(input logic [6:0] addr, input logic [7:0] ptr,
		input logic [7:0] msb, input logic [7:0] lsb);
		sda_low <= 1'b1;
		tick(5);
		send_byte({addr, 1'b0});
		send_byte(ptr);
		send_byte(msb);
		send_byte(lsb);
		scl <= 1'b0;
		tick(2);
		sda_low <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(5);
		sda_low <= 1'b0;
		tick(10);
	endtask : write_frame
endmodule : i2c_host_model

// *** verification/tb.sv ***
/*
 * Self-checking bench of the I/O control block driven by the two-wire host model.
 * Assumes the design, checker and host model files are compiled first.
 */
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic conversion_active = 1'b0;
	logic [7:0] io_pin_n_in = 8'h00;
	logic scl_in, sda_in, sda_oe, host_low, adc_buf_power, adc_range_2x, dac_range_2x;
	logic [7:0] io_pin_n_out, io_pin_n_oe, pulldown_en, dac_drive_en, adc_sample_en;
	logic [7:0] gpio_in_state;
	logic [7:0][11:0] dac_active;
	int err_total = 0;
	int checks = 0;
	always #50 clk = ~clk;
	assign sda_in = ~(host_low | sda_oe);
	i2c_host_model u_i2c_host_model (.clk, .sda_line(sda_in), .scl(scl_in), .sda_low(host_low));
	io_config_and_dac_write_ctrl u_io_config_and_dac_write_ctrl (.clk, .nrst, .scl_in, .sda_in,
		.sda_out(), .sda_oe, .conversion_active, .io_pin_n_in, .io_pin_n_out, .io_pin_n_oe,
		.pulldown_en, .dac_drive_en, .adc_sample_en, .gpio_in_state, .dac_active,
		.adc_buf_power, .adc_range_2x, .dac_range_2x);
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic check12(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check12
	function automatic logic [7:0] ana();
		return {5'h0, adc_buf_power, adc_range_2x, dac_range_2x};
	endfunction : ana
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic wr(input logic [7:0] ptr, input logic [7:0] msb, input logic [7:0] lsb);
		int n;
		n = u_i2c_host_model.nacks;
		u_i2c_host_model.write_frame(7'h10, ptr, msb, lsb);
		check8(8'(u_i2c_host_model.nacks - n), 8'h00);
	endtask : wr
	task automatic conv(input logic v);
		@(posedge clk) conversion_active <= v;
		step(2);
	endtask : conv
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_gen_ctrl();
		// Unused control bits are always written as zeros.
		wr(8'h03, 8'h03, 8'h30);
		check8(ana(), 8'h03);
		conv(1'b1);
		check8(ana(), 8'h07);
		conv(1'b0);
		wr(8'h03, 8'h01, 8'h00);
		check8(ana(), 8'h04);
		conv(1'b1);
		check8(ana(), 8'h04);
		wr(8'h03, 8'h00, 8'h00);
		check8(ana(), 8'h00);
		// One range bit alone, so a swapped pair of range outputs shows up.
		wr(8'h03, 8'h00, 8'h20);
		check8(ana(), 8'h02);
		conv(1'b0);
		$display("test gen_ctrl done");
	endtask : test_gen_ctrl
	task automatic test_maps();
		// The pad shows the level that the pin itself drives.
		@(posedge clk) io_pin_n_in <= 8'h02;
		wr(8'h05, 8'h00, 8'h82);
		check8(pulldown_en, 8'h7D);
		wr(8'h04, 8'h00, 8'h03);
		check8(adc_sample_en & dac_drive_en, 8'h02);
		wr(8'h08, 8'h00, 8'h02);
		wr(8'h09, 8'h00, 8'h02);
		check8(dac_drive_en | adc_sample_en, 8'h81);
		check8(io_pin_n_oe & io_pin_n_out, 8'h02);
		wr(8'h0A, 8'h00, 8'h02);
		check8(io_pin_n_oe & gpio_in_state, 8'h02);
		wr(8'h0C, 8'h00, 8'h02);
		check8(io_pin_n_out, 8'h00);
		wr(8'h0D, 8'h00, 8'h02);
		check8(io_pin_n_oe, 8'h00);
		wr(8'h06, 8'h00, 8'h01);
		check8(pulldown_en | adc_sample_en, 8'h01);
		$display("test maps done");
	endtask : test_maps
	task automatic test_lock();
		logic [7:0] codes [7] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0D};
		wr(8'h03, 8'h00, 8'h80);
		foreach (codes[i]) wr(codes[i], 8'h00, 8'hFF);
		check8(dac_drive_en, 8'h80);
		check8(pulldown_en | adc_sample_en | io_pin_n_oe, 8'h01);
		// Unlock on an idle device before the pins are touched again.
		wr(8'h03, 8'h00, 8'h00);
		wr(8'h05, 8'h00, 8'h81);
		check8(dac_drive_en | pulldown_en, 8'h81);
		$display("test lock done");
	endtask : test_lock
	task automatic test_dac_load();
		wr(8'h12, 8'h0A, 8'hBC);
		check12(dac_active[2], 12'hABC);
		wr(8'h17, 8'h0F, 8'hFF);
		check12(dac_active[7], 12'hFFF);
		wr(8'h07, 8'h00, 8'h01);
		wr(8'h13, 8'h05, 8'h55);
		check12(dac_active[3], 12'h000);
		wr(8'h07, 8'h00, 8'h02);
		check12(dac_active[3], 12'h555);
		wr(8'h14, 8'h01, 8'h23);
		check12(dac_active[4], 12'h000);
		wr(8'h07, 8'h00, 8'h03);
		wr(8'h15, 8'h04, 8'h56);
		check12(dac_active[5], 12'h000);
		$display("test dac_load done");
	endtask : test_dac_load
	task automatic test_broadcast();
		int n;
		wr(8'h07, 8'h00, 8'h00);
		wr(8'h03, 8'h00, 8'h40);
		wr(8'h12, 8'h03, 8'h21);
		check12(dac_active[0], 12'h321);
		check12(dac_active[7], 12'h321);
		check12(dac_active[2], 12'hABC);
		// A frame for another address is neither acknowledged nor applied.
		n = u_i2c_host_model.nacks;
		u_i2c_host_model.write_frame(7'h11, 8'h05, 8'h00, 8'h00);
		check8(8'(u_i2c_host_model.nacks - n), 8'h04);
		check8(dac_drive_en, 8'h81);
		@(posedge clk) nrst <= 1'b0;
		step(2);
		check8(pulldown_en & ~dac_drive_en, 8'hFF);
		check12(dac_active[0], 12'h000);
		@(posedge clk) nrst <= 1'b1;
		step(2);
		$display("test broadcast done");
	endtask : test_broadcast
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		step(2);
		check8(pulldown_en & ~(dac_drive_en | io_pin_n_oe), 8'hFF);
		check8(ana() | adc_sample_en, 8'h00);
		test_gen_ctrl();
		test_maps();
		test_lock();
		test_dac_load();
		test_broadcast();
		finish_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("timeout at %0t", $time);
		finish_test();
	end
endmodule : tb
